// ==== logic/swi_cp_pkg.sv ====
// Purpose: shared constants and types for the trap and coprocessor executor
// Assumes: 32-bit instruction words, word-per-register bus map
// Notes: offsets are byte addresses on the register bus
package swi_cp_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INSTR = 8'h04;
	localparam logic [7:0] OFS_INSTR_ADDR = 8'h08;
	localparam logic [7:0] OFS_STATUS_REG = 8'h0C;
	localparam logic [7:0] OFS_SAVED = 8'h10;
	localparam logic [7:0] OFS_LINK = 8'h14;
	localparam logic [7:0] OFS_PC = 8'h18;
	localparam logic [7:0] OFS_BASE = 8'h1C;
	localparam logic [7:0] OFS_RESULT = 8'h20;
	localparam logic [7:0] OFS_CYCLES = 8'h24;
	localparam logic [7:0] OFS_LAST_ADDR = 8'h28;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_RETURN_BIT = 1;
	// ==========================================================
	// result register fields
	localparam int RES_BUSY_BIT = 0;
	localparam int RES_EXEC_BIT = 1;
	localparam int RES_FOREIGN_BIT = 2;
	localparam int RES_TRAP_LSB = 4;
	// ==========================================================
	// instruction fields
	localparam int COND_LSB = 28;
	localparam int CLASS_LSB = 24;
	localparam int CP_BIT4 = 4;
	localparam int XFER_P_BIT = 24;
	localparam int XFER_U_BIT = 23;
	localparam int XFER_W_BIT = 21;
	localparam int XFER_L_BIT = 20;
	localparam int RN_LSB = 16;
	localparam int CP_NUM_LSB = 8;
	localparam int MODE_LSB = 0;
	localparam int OFFSET_SHIFT = 2;
	localparam logic [3:0] CLASS_SWI = 4'hF;
	localparam logic [3:0] CLASS_CDP = 4'hE;
	localparam logic [2:0] CLASS_XFER = 3'b110;
	localparam logic [3:0] PC_REG_NUM = 4'hF;
	// ==========================================================
	// values and counts
	localparam logic [31:0] SWI_VECTOR = 32'h0000_0008;
	localparam logic [31:0] PC_READ_AHEAD = 32'h0000_0008;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [31:0] STATUS_RST = 32'h0000_0010;
	localparam logic [4:0] SVC_MODE = 5'h13;
	localparam logic [1:0] SWI_S_CYCLES = 2'h2;
	// ==========================================================
	typedef enum logic [1:0] {
		TRAP_NONE = 2'h0,
		TRAP_SWI = 2'h1,
		TRAP_UNDEF = 2'h2,
		TRAP_ABORT = 2'h3
	} trap_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_COND = 6'b000010,
		ST_SWI = 6'b000100,
		ST_CP_WAIT = 6'b001000,
		ST_XFER = 6'b010000,
		ST_FINISH = 6'b100000
	} exec_state_t;
endpackage

// ==== logic/cond_check.sv ====
// Purpose: evaluates an instruction condition field against the flags
// Assumes: flags given as negative, zero, carry, overflow
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module cond_check (
	input wire logic [3:0] cond_i, // condition field
	input wire logic [3:0] flags_i, // n z c v
	output logic pass_o // condition holds
);
	logic n, z, c, v, base_pass;
	assign n = flags_i[3];
	assign z = flags_i[2];
	assign c = flags_i[1];
	assign v = flags_i[0];
	// ==========================================================
	// odd codes are the inverse of the even code below them
	always_comb begin
		unique case (cond_i[3:1])
			3'h0: base_pass = z;
			3'h1: base_pass = c;
			3'h2: base_pass = n;
			3'h3: base_pass = v;
			3'h4: base_pass = c & ~z;
			3'h5: base_pass = (n == v);
			3'h6: base_pass = ~z & (n == v);
			3'h7: base_pass = 1'b1;
		endcase
	end
	// code 15 is treated as never
	assign pass_o = cond_i[0] ? ~base_pass : base_pass;
endmodule
`default_nettype wire

// ==== logic/swi_cp_exec.sv ====
// Purpose: executes software trap, coprocessor data op and coprocessor transfers
// Assumes: classic wishbone slave, single clock, coprocessor moves its own data
// Notes: with no coprocessor fitted data operations and transfers trap as undefined
//
// Overview of operation
// [RULE_01] run an instruction only when its condition field passes
// [RULE_02] software trap: supervisor mode, pc to 0x08, status saved
// [RULE_03] software trap: link gets address of the following word
// [RULE_04] return command copies link to pc and saved status back
// [RULE_05] nested software trap overwrites link and saved status
// [RULE_06] low 24 bits of a software trap are ignored
// [RULE_07] software trap costs two sequential and one non-sequential cycle
// [RULE_08] without a coprocessor all coprocessor instructions trap undefined; here only data operations and transfers trap, bit 4 set in class 0xE does not
// [RULE_09] data operation: no wait for completion, no result back
// [RULE_10] data operation decode looks only at bit 4 and bits 31:24
// [RULE_11] coprocessor answers only to its own number 0 to 15
// [RULE_12] data operation costs one sequential plus one internal per busy cycle
// [RULE_13] core drives addresses, coprocessor moves data and decides count
// [RULE_14] coprocessor uses the length bit to choose short or long transfer
// [RULE_15] word offset shifted left 2, added when up, subtracted when down
// [RULE_16] offset before first word when pre, base written back only when W
// [RULE_17] each further word is four bytes above the one before
// [RULE_18] low two address bits go out unaltered
// [RULE_19] pc as base reads instruction address plus 8, no write-back
// [RULE_20] on abort: write-back still done, state kept, abort trap taken
// [RULE_21] coprocessor keeps interrupted transfers restartable
// [RULE_22] transfer costs (n-1) sequential, two non-sequential, busy internals
// [RULE_23] a refusing coprocessor raises both absent and busy
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module swi_cp_exec
	import swi_cp_pkg::*;
#(
	parameter bit COPROC_PRESENT = 1'b0,
	parameter logic [31:0] UNDEF_VECTOR = 32'h0000_0004,
	parameter logic [31:0] ABORT_VECTOR = 32'h0000_0010
) (
	input wire logic clk_i, // system clock
	input wire logic rst_i, // synchronous reset, high
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // bus write
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte lanes
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // bus acknowledge
	input wire logic coproc_absent_i, // no coprocessor takes the instruction
	input wire logic coproc_busy_i, // coprocessor holds the core
	input wire logic coproc_last_i, // coprocessor marks the final word
	input wire logic mem_abort_i, // memory manager aborts this word
	output logic [31:0] cp_instr_o, // instruction offered to coprocessors
	output logic cp_offer_o, // instruction offer is live
	output logic [31:0] mem_addr_o, // transfer address
	output logic mem_req_o, // transfer word this cycle
	output logic mem_we_o, // store to memory
	output logic mem_seq_o, // sequential word
	output logic trap_o // a trap was taken, one cycle
);
	import swi_cp_pkg::*;

	// ==========================================================
	// bus slave
	logic ack_q, bus_req, wr_en, start_w, return_w;
	logic [31:0] dat_q, rd_data;
	exec_state_t state_q;
	logic idle;
	assign bus_req = wb_cyc_i & wb_stb_i;
	// write lands on the edge the master samples ack
	assign wr_en = bus_req & wb_we_i & ack_q;
	assign idle = (state_q == ST_IDLE);
	assign start_w = wr_en & (wb_adr_i == OFS_CTRL) & wb_sel_i[0]
		& wb_dat_i[CTRL_START_BIT] & idle;
	assign return_w = wr_en & (wb_adr_i == OFS_CTRL) & wb_sel_i[0]
		& wb_dat_i[CTRL_RETURN_BIT] & idle & ~wb_dat_i[CTRL_START_BIT];

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req & ~ack_q;
			dat_q <= rd_data;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ==========================================================
	// architectural and result registers
	logic [31:0] instr_q, iaddr_q, status_q, saved_q, link_q, pc_q, base_q, addr_q;
	logic [7:0] cyc_s_q, cyc_n_q, cyc_i_q;
	logic exec_q, foreign_q, abort_q, req_q, we_q, seq_q, offer_q, trap_q;
	trap_t trap_kind_q;
	logic [1:0] swi_cnt_q;

	// ==========================================================
	// decode
	logic cond_pass, is_swi, is_cdp, is_xfer, pre_w, up_w, wb_w, pc_base;
	logic [3:0] rn;
	logic [31:0] base_val, offset, mod_base, first_addr;
	cond_check u_cond (
		.cond_i(instr_q[COND_LSB +: 4]),
		.flags_i(status_q[31:28]),
		.pass_o(cond_pass)
	);
	// trap comment field below bit 24 is never looked at
	assign is_swi = (instr_q[CLASS_LSB +: 4] == CLASS_SWI); // RULE_06
	assign is_cdp = (instr_q[CLASS_LSB +: 4] == CLASS_CDP) & ~instr_q[CP_BIT4]; // RULE_10
	assign is_xfer = (instr_q[CLASS_LSB + 1 +: 3] == CLASS_XFER);
	assign pre_w = instr_q[XFER_P_BIT];
	assign up_w = instr_q[XFER_U_BIT];
	assign rn = instr_q[RN_LSB +: 4];
	assign pc_base = (rn == PC_REG_NUM);
	assign base_val = pc_base ? iaddr_q + PC_READ_AHEAD : base_q; // RULE_19
	// pc is never written back even with W set
	assign wb_w = instr_q[XFER_W_BIT] & ~pc_base; // RULE_19
	assign offset = {22'h00_0000, instr_q[7:0], 2'h0}; // RULE_15
	assign mod_base = up_w ? base_val + offset : base_val - offset; // RULE_15
	// low address bits pass through untouched
	assign first_addr = pre_w ? mod_base : base_val; // RULE_16 RULE_18

	// ==========================================================
	// coprocessor answer
	logic cp_refuse, cp_wait, cp_take, enter_undef, last_word;
	// absent with busy is an explicit refusal
	assign cp_refuse = coproc_absent_i; // RULE_23
	assign cp_wait = coproc_busy_i & ~coproc_absent_i;
	assign cp_take = ~coproc_busy_i & ~coproc_absent_i;
	// the coprocessor, not the core, ends the burst
	assign last_word = coproc_last_i; // RULE_13
	assign enter_undef = (state_q == ST_COND) & cond_pass & ~is_swi & (is_cdp | is_xfer)
		& ~COPROC_PRESENT; // RULE_08

	// ==========================================================
	// sequencer
	exec_state_t state_d;
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start_w) begin
					state_d = ST_COND;
				end
			end
			ST_COND: begin
				if (!cond_pass) begin
					state_d = ST_FINISH; // RULE_01
				end else if (is_swi) begin
					state_d = ST_SWI;
				end else if ((is_cdp | is_xfer) & COPROC_PRESENT) begin
					state_d = ST_CP_WAIT;
				end else begin
					state_d = ST_FINISH;
				end
			end
			ST_SWI: begin
				if (swi_cnt_q == SWI_S_CYCLES) begin
					state_d = ST_FINISH; // RULE_07
				end
			end
			ST_CP_WAIT: begin
				if (cp_refuse) begin
					state_d = ST_FINISH;
				end else if (cp_take) begin
					// data operation leaves at once, work overlaps
					state_d = is_cdp ? ST_FINISH : ST_XFER; // RULE_09
				end
			end
			ST_XFER: begin
				if (last_word) begin
					state_d = ST_FINISH;
				end
			end
			ST_FINISH: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// trap events
	logic swi_fire, undef_fire, xfer_done, abort_fire, trap_fire;
	logic [31:0] trap_pc;
	assign swi_fire = (state_q == ST_SWI) & (swi_cnt_q == SWI_S_CYCLES);
	assign undef_fire = enter_undef | ((state_q == ST_CP_WAIT) & cp_refuse);
	assign xfer_done = (state_q == ST_XFER) & last_word;
	assign abort_fire = xfer_done & (abort_q | mem_abort_i); // RULE_20
	assign trap_fire = swi_fire | undef_fire | abort_fire;
	assign trap_pc = swi_fire ? SWI_VECTOR : (undef_fire ? UNDEF_VECTOR : ABORT_VECTOR);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swi_cnt_q <= 2'h0;
		end else if (state_q == ST_SWI) begin
			swi_cnt_q <= swi_cnt_q + 2'h1;
		end else begin
			swi_cnt_q <= 2'h0;
		end
	end

	// ==========================================================
	// status, saved status, link, pc
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_q <= STATUS_RST;
			saved_q <= 32'h0000_0000;
			link_q <= 32'h0000_0000;
			pc_q <= 32'h0000_0000;
		end else if (swi_fire) begin
			// a nested trap simply overwrites the return state
			saved_q <= status_q; // RULE_02 RULE_05
			link_q <= iaddr_q + WORD_STEP; // RULE_03 RULE_05
			status_q[MODE_LSB +: 5] <= SVC_MODE; // RULE_02
			pc_q <= trap_pc; // RULE_02
		end else if (undef_fire | abort_fire) begin
			pc_q <= trap_pc; // RULE_08 RULE_20
		end else if (return_w) begin
			pc_q <= link_q; // RULE_04
			status_q <= saved_q; // RULE_04
		end else if (wr_en & idle) begin
			if (wb_adr_i == OFS_STATUS_REG) begin
				status_q <= merge(status_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_SAVED) begin
				saved_q <= merge(saved_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_LINK) begin
				link_q <= merge(link_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_PC) begin
				pc_q <= merge(pc_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ==========================================================
	// instruction, its address and the base register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			instr_q <= 32'h0000_0000;
			iaddr_q <= 32'h0000_0000;
			base_q <= 32'h0000_0000;
		end else if (xfer_done) begin
			// write-back happens even when the burst aborted
			if (wb_w) begin
				base_q <= mod_base; // RULE_16 RULE_20
			end
		end else if (wr_en & idle) begin
			if (wb_adr_i == OFS_INSTR) begin
				instr_q <= merge(instr_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_INSTR_ADDR) begin
				iaddr_q <= merge(iaddr_q, wb_dat_i, wb_sel_i);
			end
			if (wb_adr_i == OFS_BASE) begin
				base_q <= merge(base_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	// ==========================================================
	// cycle accounting: sequential, non-sequential, internal
	always_ff @(posedge clk_i) begin
		if (rst_i || start_w) begin
			cyc_s_q <= 8'h00;
			cyc_n_q <= 8'h00;
			cyc_i_q <= 8'h00;
		end else begin
			if ((state_q == ST_SWI) && (swi_cnt_q != SWI_S_CYCLES)) begin
				cyc_s_q <= cyc_s_q + 8'h01; // RULE_07
			end else if ((state_q == ST_CP_WAIT) && cp_take && is_cdp) begin
				cyc_s_q <= cyc_s_q + 8'h01; // RULE_12
			end else if ((state_q == ST_XFER) && seq_q) begin
				cyc_s_q <= cyc_s_q + 8'h01; // RULE_22
			end
			if (swi_fire) begin
				cyc_n_q <= cyc_n_q + 8'h01; // RULE_07
			end else if ((state_q == ST_CP_WAIT) && cp_take && !is_cdp) begin
				cyc_n_q <= cyc_n_q + 8'h01; // RULE_22
			end else if (xfer_done) begin
				cyc_n_q <= cyc_n_q + 8'h01; // RULE_22
			end
			if ((state_q == ST_CP_WAIT) && cp_wait) begin
				cyc_i_q <= cyc_i_q + 8'h01; // RULE_12 RULE_22
			end
		end
	end

	// ==========================================================
	// transfer port
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= 32'h0000_0000;
			req_q <= 1'b0;
			we_q <= 1'b0;
			seq_q <= 1'b0;
			abort_q <= 1'b0;
			offer_q <= 1'b0;
		end else begin
			offer_q <= (state_d == ST_CP_WAIT);
			if ((state_q == ST_CP_WAIT) && cp_take && !is_cdp) begin
				addr_q <= first_addr; // RULE_13 RULE_16
				req_q <= 1'b1;
				we_q <= ~instr_q[XFER_L_BIT];
				seq_q <= 1'b0;
				abort_q <= 1'b0;
			end else if (state_q == ST_XFER) begin
				// an abort is remembered and the burst runs to its end
				abort_q <= abort_q | mem_abort_i; // RULE_20
				if (last_word) begin
					req_q <= 1'b0;
					seq_q <= 1'b0;
				end else begin
					addr_q <= addr_q + WORD_STEP; // RULE_17
					seq_q <= 1'b1;
				end
			end
		end
	end
	assign mem_addr_o = addr_q;
	assign mem_req_o = req_q;
	assign mem_we_o = we_q;
	assign mem_seq_o = seq_q;
	assign cp_offer_o = offer_q;
	assign cp_instr_o = instr_q;

	// ==========================================================
	// outcome flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			exec_q <= 1'b0;
			foreign_q <= 1'b0;
			trap_kind_q <= TRAP_NONE;
			trap_q <= 1'b0;
		end else begin
			trap_q <= trap_fire;
			if (start_w) begin
				exec_q <= 1'b0;
				foreign_q <= 1'b0;
				trap_kind_q <= TRAP_NONE;
			end else if (state_q == ST_COND) begin
				exec_q <= cond_pass; // RULE_01
				foreign_q <= cond_pass & ~is_swi & ~is_cdp & ~is_xfer;
			end
			if (swi_fire) begin
				trap_kind_q <= TRAP_SWI;
			end else if (undef_fire) begin
				trap_kind_q <= TRAP_UNDEF;
			end else if (abort_fire) begin
				trap_kind_q <= TRAP_ABORT;
			end
		end
	end
	assign trap_o = trap_q;

	// ==========================================================
	// read mux, unmapped words read zero
	logic [31:0] result_w;
	assign result_w = {26'h000_0000, trap_kind_q, 1'b0, foreign_q, exec_q, ~idle};
	always_comb begin
		unique case (wb_adr_i)
			OFS_INSTR: rd_data = instr_q;
			OFS_INSTR_ADDR: rd_data = iaddr_q;
			OFS_STATUS_REG: rd_data = status_q;
			OFS_SAVED: rd_data = saved_q;
			OFS_LINK: rd_data = link_q;
			OFS_PC: rd_data = pc_q;
			OFS_BASE: rd_data = base_q;
			OFS_RESULT: rd_data = result_w;
			OFS_CYCLES: rd_data = {8'h00, cyc_s_q, cyc_n_q, cyc_i_q};
			OFS_LAST_ADDR: rd_data = addr_q;
			default: rd_data = 32'h0000_0000;
		endcase
	end
endmodule
`default_nettype wire

// ==== tb/swi_cp_exec_checker.sv ====
// Purpose: port-level assertions for the trap and coprocessor executor
// Assumes: one clock, synchronous active-high reset
// Notes: bound onto every executor instance
`timescale 1ns/1ps
`default_nettype none
module swi_cp_exec_checker (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_ack_o, // bus ack
	input wire logic coproc_absent_i, // absent
	input wire logic coproc_busy_i, // busy
	input wire logic coproc_last_i, // last word
	input wire logic mem_abort_i, // abort
	input wire logic [31:0] cp_instr_o, // offered instr
	input wire logic cp_offer_o, // offer live
	input wire logic [31:0] mem_addr_o, // address
	input wire logic mem_req_o, // word valid
	input wire logic mem_seq_o, // sequential
	input wire logic trap_o // trap pulse
);
	// ==========================================================
	// helpers
	logic abort_seen_q;
	wire logic take_w = cp_offer_o && !coproc_absent_i && !coproc_busy_i;
	wire logic cdp_w = cp_instr_o[27:24] == 4'hE && !cp_instr_o[4];
	// an abort on any word counts, not only on the last
	always_ff @(posedge clk_i) begin
		if (rst_i || !mem_req_o) abort_seen_q <= 1'b0;
		else if (mem_abort_i) abort_seen_q <= 1'b1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// properties
	property p_ack_resp; $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_seq_first; $rose(mem_req_o) |-> !mem_seq_o; endproperty
	property p_step;
		mem_req_o && $past(mem_req_o) |-> mem_seq_o && mem_addr_o == $past(mem_addr_o) + 32'h4;
	endproperty
	property p_last_end; mem_req_o && coproc_last_i |=> !mem_req_o; endproperty
	property p_req_after; take_w && cp_instr_o[27:25] == 3'b110 |=> mem_req_o; endproperty
	property p_cdp_no_wait; take_w && cdp_w |=> !cp_offer_o && !mem_req_o; endproperty
	property p_refuse_trap; cp_offer_o && coproc_absent_i |-> ##[1:4] trap_o; endproperty
	property p_abort_trap;
		mem_req_o && coproc_last_i && (abort_seen_q || mem_abort_i) |-> ##[1:3] trap_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack late");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_seq_first: assert property (p_seq_first) else $error("first word sequential");
	a_step: assert property (p_step) else $error("bad word step");
	a_last_end: assert property (p_last_end) else $error("words after last");
	a_req_after: assert property (p_req_after) else $error("no transfer");
	a_cdp_no_wait: assert property (p_cdp_no_wait) else $error("data op waits");
	a_refuse_trap: assert property (p_refuse_trap) else $error("no undef trap");
	a_abort_trap: assert property (p_abort_trap) else $error("no abort trap");
	c_xfer: cover property (mem_req_o && mem_seq_o);
	c_refuse: cover property (cp_offer_o && coproc_absent_i);
	c_busy: cover property (cp_offer_o && coproc_busy_i && !coproc_absent_i);
endmodule
bind swi_cp_exec swi_cp_exec_checker chk_inst (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.coproc_absent_i(coproc_absent_i), .coproc_busy_i(coproc_busy_i),
	.coproc_last_i(coproc_last_i), .mem_abort_i(mem_abort_i), .cp_instr_o(cp_instr_o),
	.cp_offer_o(cp_offer_o), .mem_addr_o(mem_addr_o), .mem_req_o(mem_req_o),
	.mem_seq_o(mem_seq_o), .trap_o(trap_o));
`default_nettype wire

// ==== tb/cp_mem_model.sv ====
// Purpose: coprocessor plus memory manager seen from the core
// Assumes: answers driven from registered core outputs
// Notes: released lines toggle so stale values are never trusted
`timescale 1ns/1ps
`default_nettype none
module cp_mem_model #(
	parameter logic [3:0] CP_ID = 4'h1
) (
	input wire logic clk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [31:0] cp_instr_i, // offered instr
	input wire logic cp_offer_i, // offer live
	input wire logic mem_req_i, // word presented
	input wire logic [31:0] mem_addr_i, // word address
	input wire logic refuse_i, // refuse all offers
	input wire logic [3:0] busy_n_i, // busy cycles
	input wire logic [3:0] words_n_i, // long length
	input wire logic [3:0] abort_at_i, // aborted word
	output logic absent_o, // absent
	output logic busy_o, // busy
	output logic last_o, // last word
	output logic abort_o // abort
);
	logic [3:0] bcnt_q = 4'h0;
	logic [3:0] wcnt_q = 4'h0;
	logic tog_q = 1'b0;
	logic [31:0] log_q [8];
	wire logic mine = !refuse_i && cp_instr_i[11:8] == CP_ID;
	wire logic [3:0] len = cp_instr_i[22] ? words_n_i : 4'h1;
	assign absent_o = cp_offer_i ? !mine : tog_q;
	assign busy_o = cp_offer_i ? (!mine || bcnt_q < busy_n_i) : !tog_q;
	assign last_o = mem_req_i ? wcnt_q == len - 4'h1 : tog_q;
	assign abort_o = mem_req_i ? wcnt_q == abort_at_i : !tog_q;
	always @(posedge clk_i) begin
		tog_q <= !tog_q;
		bcnt_q <= (cp_offer_i && !rst_i) ? bcnt_q + 4'h1 : 4'h0;
		if (mem_req_i) begin
			log_q[wcnt_q[2:0]] <= mem_addr_i;
			wcnt_q <= wcnt_q + 4'h1;
		// fresh count per offer keeps a retry repeatable
		end else if (cp_offer_i || rst_i) begin
			wcnt_q <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// ==== tb/swi_cp_exec_tb_top.sv ====
// Purpose: self-checking bench for the trap and coprocessor executor
// Assumes: executor built with a coprocessor port fitted
// Notes: registers reached over classic wishbone single cycles
`timescale 1ns/1ps
`default_nettype none
module swi_cp_exec_tb_top;
	import swi_cp_pkg::*;
	localparam logic [31:0] undef_v = 32'h0000_0004;
	localparam logic [31:0] abort_v = 32'h0000_0010;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, cp_instr, maddr;
	logic ack, absent, busy, last_w, abort_w, offer, req, mwe, mseq, trap;
	logic refuse = 1'b0;
	logic [3:0] busy_n = 4'h0, words_n = 4'h1, abort_at = 4'hF;
	int err_total = 0, checks_done = 0, cyc_cnt = 0;
	logic [31:0] t_ins [4] = '{32'hEDE1_0103, 32'hEC71_0104, 32'hED51_0102, 32'hEDDF_0102};
	logic [31:0] t_first [4] = '{32'h0000_100D, 32'h0000_1001, 32'h0000_0FF9, 32'h0000_0410};
	logic [31:0] t_base [4] = '{32'h0000_100D, 32'h0000_0FF1, 32'h0000_1001, 32'h0000_1001};
	logic [31:0] r_ins [4] = '{32'hEE00_0100, 32'hED91_0100, 32'hEC81_0100, 32'hEE00_0200};
	always #4 clk_i = ~clk_i;
	swi_cp_exec #(.COPROC_PRESENT(1'b1), .UNDEF_VECTOR(undef_v), .ABORT_VECTOR(abort_v))
	swi_cp_exec_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .coproc_absent_i(absent), .coproc_busy_i(busy),
		.coproc_last_i(last_w), .mem_abort_i(abort_w), .cp_instr_o(cp_instr),
		.cp_offer_o(offer), .mem_addr_o(maddr), .mem_req_o(req), .mem_we_o(mwe),
		.mem_seq_o(mseq), .trap_o(trap));
	cp_mem_model cp_mem_model_inst (.clk_i(clk_i), .rst_i(rst_i), .cp_instr_i(cp_instr),
		.cp_offer_i(offer), .mem_req_i(req), .mem_addr_i(maddr), .refuse_i(refuse),
		.busy_n_i(busy_n), .words_n_i(words_n), .abort_at_i(abort_at), .absent_o(absent),
		.busy_o(busy), .last_o(last_w), .abort_o(abort_w));
	// ==========================================================
	// tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask
	// polls until the executor leaves busy
	task automatic run(input logic [31:0] ins, input logic [31:0] ia);
		logic [31:0] q;
		wr(OFS_INSTR, ins);
		wr(OFS_INSTR_ADDR, ia);
		wr(OFS_CTRL, 32'h1);
		do bus(OFS_RESULT, 1'b0, 32'h0, q); while (q[0] !== 1'b0);
	endtask
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			$display("Error at %0t: timeout", $time);
			tally_and_finish();
		end
	end
	// ==========================================================
	// tests
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rc(OFS_STATUS_REG, STATUS_RST);
		rc(8'hFC, 32'h0);
		$display("test reset done");
		run(32'hEF12_3456, 32'h0000_0100);
		rc(OFS_PC, SWI_VECTOR);
		rc(OFS_SAVED, STATUS_RST);
		rc(OFS_STATUS_REG, {STATUS_RST[31:5], SVC_MODE});
		rc(OFS_LINK, 32'h0000_0104);
		rc(OFS_CYCLES, 32'h0002_0100);
		rc(OFS_RESULT, 32'h0000_0012);
		wr(OFS_STATUS_REG, 32'h4000_0013);
		run(32'hEFFF_FFFF, 32'h0000_0200);
		rc(OFS_LINK, 32'h0000_0204);
		rc(OFS_SAVED, 32'h4000_0013);
		wr(OFS_STATUS_REG, 32'h8000_001F);
		wr(OFS_CTRL, 32'h2);
		rc(OFS_PC, 32'h0000_0204);
		rc(OFS_STATUS_REG, 32'h4000_0013);
		$display("test trap and return done");
		run(32'h1F00_0000, 32'h0000_0300);
		rc(OFS_RESULT, 32'h0);
		rc(OFS_PC, 32'h0000_0204);
		run(32'h0F00_0000, 32'h0000_0300);
		rc(OFS_RESULT, 32'h0000_0012);
		$display("test condition done");
		refuse <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (i == 3) refuse <= 1'b0;
			wr(OFS_PC, 32'h0);
			run(r_ins[i], 32'h0000_0400);
			rc(OFS_RESULT, 32'h0000_0022);
			rc(OFS_PC, undef_v);
		end
		$display("test refusal done");
		busy_n <= 4'h3;
		run(32'hEEAB_C1E0, 32'h0000_0400);
		rc(OFS_RESULT, 32'h0000_0002);
		rc(OFS_CYCLES, 32'h0001_0003);
		chk(cp_instr, 32'hEEAB_C1E0);
		busy_n <= 4'h1;
		words_n <= 4'h2;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_BASE, 32'h0000_1001);
			run(t_ins[i], 32'h0000_0400);
			chk(cp_mem_model_inst.log_q[0], t_first[i]);
			chk(cp_mem_model_inst.log_q[1], t_first[i] + WORD_STEP);
			chk({28'h0, cp_mem_model_inst.wcnt_q}, 32'h2);
			rc(OFS_BASE, t_base[i]);
			rc(OFS_CYCLES, 32'h0001_0201);
			chk({31'h0, mwe}, {31'h0, ~t_ins[i][XFER_L_BIT]});
		end
		$display("test transfers done");
		words_n <= 4'h3;
		abort_at <= 4'h1;
		wr(OFS_BASE, 32'h0000_1001);
		run(32'hEDE1_0103, 32'h0000_0400);
		rc(OFS_RESULT, 32'h0000_0032);
		rc(OFS_PC, abort_v);
		rc(OFS_BASE, 32'h0000_100D);
		rc(OFS_STATUS_REG, 32'h4000_0013);
		rc(OFS_LAST_ADDR, 32'h0000_1015);
		$display("test abort done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
